// ---- rtl/crg_codec.sv ----
/*
 * Compatibility registration codec: builds the registration control
 * packet as a byte stream with retransmission, and parses received ones.
 * Assumes an APB master on the register port and a framer that presents
 * the header beside every payload byte.
 */
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "crg_defs.svh"
module crg_codec #(
   parameter int RETX_CYCLES = `CRG_RETX_TIME_US * `CRG_CLK_MHZ,
   parameter int MAX_RETX    = `CRG_MAX_RETX
) (
   // Clock and reset.
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   // APB slave.
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [7:0]        paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   // Transmit byte stream.
   output logic                   tx_valid_o,
   output logic      [7:0]        tx_byte_o,
   output logic                   tx_last_o,
   output crg_pkg::crg_hdr_t      tx_hdr_o,
   input  wire logic              tx_ready_i,
   // Receive byte stream.
   input  wire logic              rx_valid_i,
   input  wire logic [7:0]        rx_byte_i,
   input  wire logic              rx_last_i,
   input  wire crg_pkg::crg_hdr_t rx_hdr_i
);
   import crg_pkg::*;

   // The wait counter and retry counter widths bound the parameters.
   initial begin
      if (RETX_CYCLES < 1 || MAX_RETX < 0 || MAX_RETX > 15) begin
         $error("crg_codec: RETX_CYCLES or MAX_RETX out of range");
      end
   end

   // Register state.
   logic [31:0] ctrl_q, ctrl_d;        // Control word, start bit not kept.
   logic [21:0] ids_q, ids_d;          // Switch and node identifiers.
   logic [47:0] hw_q, hw_d;            // Own hardware address.
   logic [31:0] prdata_q, prdata_d;    // Read data.
   logic        pready_q, pready_d;    // One wait state answer.
   logic        pslverr_q, pslverr_d;  // Unmapped address.
   // Transmit state.
   crg_state_t  state_q, state_d;      // Sequencer.
   logic [5:0]  idx_q, idx_d;          // Payload byte index.
   logic [31:0] timer_q, timer_d;      // Response wait.
   logic [3:0]  retx_q, retx_d;        // Retransmissions done.
   logic        failed_q, failed_d;    // Retries exhausted.
   logic        tvalid_q, tvalid_d;
   logic [7:0]  tbyte_q, tbyte_d;
   logic        tlast_q, tlast_d;
   crg_hdr_t    thdr_q, thdr_d;
   // Receive state.
   logic [5:0]  rcnt_q, rcnt_d;        // Received byte count.
   logic [63:0] rbuf_q, rbuf_d;        // First eight payload bytes.
   logic [15:0] rflags_q, rflags_d;    // Decoded flag word.
   logic [21:0] rids_q, rids_d;        // Received identifiers.
   logic [47:0] rhw_q, rhw_d;          // Received hardware address.
   logic [5:0]  rstat_q, rstat_d;      // valid,compat,legacy,down,long,path.

   // Bus decode helpers and memory hookup.
   logic        acc, wr, key_we, start, resp_seen, path_ok, rx_match;
   logic [7:0]  hop_mask;
   logic [63:0] tword, rbuf_n;
   logic [5:0]  kidx;
   logic [31:0] key_rd;
   crg_flags_t  tflags;

   assign acc    = psel_i & penable_i & pready_q;
   assign wr     = acc & pwrite_i;
   assign key_we = wr & (paddr_i[7:5] == 3'(`CRG_OFF_KEY_BASE >> 5));
   assign start  = wr & (paddr_i == `CRG_OFF_CTRL) & pwdata_i[`CRG_CTRL_START];
   assign kidx   = idx_q - 6'd8;

   crg_key_mem #(.WIDTH(32), .DEPTH(8)) u_keys (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .we_i      (key_we),
      .waddr_i   (paddr_i[4:2]),
      .wdata_i   (pwdata_i),
      .raddr_i   (kidx[4:2]),
      .rdata_o   (key_rd)
   );

   // Path aggregation: every hop below the hop count must be capable.
   assign hop_mask = 8'(({1'b0, 8'hff} << ctrl_q[`CRG_CTRL_HOPS_LSB +: 3]) & 9'h0ff);
   assign path_ok  = &(ctrl_q[`CRG_CTRL_PATH_LSB +: 8] | hop_mask); // RULE10

   // Outgoing flag word; the aggregation flag depends on direction.
   always_comb begin
      tflags = crg_flags_t'(ctrl_q[15:0]); // RULE11 RULE12 RULE13
      if (ctrl_q[`CRG_CTRL_DOWN]) begin
         tflags.aggregation_capable_flag = path_ok; // RULE10
      end
      tword = {tflags, hw_q}; // RULE14
   end

   // APB register file.
   always_comb begin
      ctrl_d    = ctrl_q;
      ids_d     = ids_q;
      hw_d      = hw_q;
      pready_d  = psel_i & penable_i & ~pready_q;
      prdata_d  = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (wr) begin
         case (paddr_i)
            `CRG_OFF_CTRL:  ctrl_d = {1'b0, pwdata_i[30:0]};
            `CRG_OFF_IDS:   ids_d = pwdata_i[21:0];
            `CRG_OFF_HW_LO: hw_d[31:0] = pwdata_i;
            `CRG_OFF_HW_HI: hw_d[47:32] = pwdata_i[15:0];
            default: ;
         endcase
      end
      // Read data and error are registered on the same edge as pready.
      if (pready_d) begin
         case (paddr_i)
            `CRG_OFF_CTRL:     prdata_d = ctrl_q;
            `CRG_OFF_IDS:      prdata_d = {10'h000, ids_q};
            `CRG_OFF_HW_LO:    prdata_d = hw_q[31:0];
            `CRG_OFF_HW_HI:    prdata_d = {16'h0000, hw_q[47:32]};
            `CRG_OFF_STATUS:   prdata_d = {rflags_q, 4'h0, retx_q, failed_q,
                                           (state_q != CRG_IDLE), rstat_q};
            `CRG_OFF_RX_IDS:   prdata_d = {10'h000, rids_q};
            `CRG_OFF_RX_HW_LO: prdata_d = rhw_q[31:0];
            `CRG_OFF_RX_HW_HI: prdata_d = {16'h0000, rhw_q[47:32]};
            default: begin
               // Key words are write only and read as zero.
               pslverr_d = (paddr_i[7:5] != 3'(`CRG_OFF_KEY_BASE >> 5)) |
                           (paddr_i[1:0] != 2'h0);
            end
         endcase
      end
   end

   // Transmit sequencer with retransmission on missing response.
   always_comb begin
      state_d  = state_q;
      idx_d    = idx_q;
      timer_d  = timer_q;
      retx_d   = retx_q;
      failed_d = failed_q;
      tvalid_d = tvalid_q;
      tbyte_d  = tbyte_q;
      tlast_d  = tlast_q;
      thdr_d   = thdr_q;
      case (state_q)
         CRG_IDLE: begin
            if (start) begin
               state_d  = CRG_FETCH;
               idx_d    = 6'd0;
               retx_d   = 4'h0;
               failed_d = 1'b0;
               thdr_d.control  = 1'b1;
               thdr_d.ctype    = `CRG_CTYPE_REG; // RULE1 RULE3
               // Requests and responses both leave in compat form.
               thdr_d.len      = pwdata_i[`CRG_CTRL_LONG] ? `CRG_LEN_LONG
                                                          : `CRG_LEN_SHORT; // RULE4
               thdr_d.switch_identifier     = ids_q[7:0]; // RULE7
               thdr_d.local_node_identifier = ids_q[21:8]; // RULE8
               thdr_d.downlink = pwdata_i[`CRG_CTRL_DOWN];
            end
         end
         CRG_FETCH: begin
            // Key memory address settles here; data arrive next cycle.
            state_d = CRG_LOAD;
         end
         CRG_LOAD: begin
            tvalid_d = 1'b1;
            tlast_d  = (idx_q == 6'(thdr_q.len - 9'd1));
            if (idx_q < 6'd8) begin
               tbyte_d = tword[6'd63 - {idx_q[2:0], 3'h0} -: 8]; // RULE14
            end else begin
               tbyte_d = key_rd[5'd31 - {kidx[1:0], 3'h0} -: 8];
            end
            state_d = CRG_SEND;
         end
         CRG_SEND: begin
            if (tx_ready_i) begin
               tvalid_d = 1'b0;
               tlast_d  = 1'b0;
               idx_d    = idx_q + 6'd1;
               if (tlast_q) begin
                  // Responses end here; requests await their answer.
                  state_d = thdr_q.downlink ? CRG_IDLE : CRG_WAIT;
                  timer_d = 32'(RETX_CYCLES);
               end else begin
                  state_d = CRG_FETCH;
               end
            end
         end
         CRG_WAIT: begin
            timer_d = timer_q - 32'd1;
            if (resp_seen) begin
               state_d = CRG_IDLE;
            end else if (timer_q == 32'd1) begin
               if (retx_q == 4'(MAX_RETX)) begin
                  state_d  = CRG_IDLE;
                  failed_d = 1'b1;
               end else begin
                  state_d = CRG_FETCH; // RULE2
                  idx_d   = 6'd0;
                  retx_d  = retx_q + 4'h1;
               end
            end
         end
         default: state_d = CRG_IDLE;
      endcase
   end

   // Receive parser.
   assign rx_match  = rx_hdr_i.control & (rx_hdr_i.ctype == `CRG_CTYPE_REG); // RULE1 RULE3
   assign rbuf_n    = (rcnt_q < 6'd8) ? {rbuf_q[55:0], rx_byte_i} : rbuf_q;
   assign resp_seen = rx_valid_i & rx_last_i & rx_match & rx_hdr_i.downlink &
                      ((rx_hdr_i.len == `CRG_LEN_SHORT) | (rx_hdr_i.len == `CRG_LEN_LONG));

   always_comb begin
      rcnt_d   = rcnt_q;
      rbuf_d   = rbuf_q;
      rflags_d = rflags_q;
      rids_d   = rids_q;
      rhw_d    = rhw_q;
      rstat_d  = rstat_q;
      if (rx_valid_i) begin
         rbuf_d = rbuf_n;
         rcnt_d = rx_last_i ? 6'd0 : rcnt_q + 6'd1;
         if (rx_last_i && rx_match) begin
            rids_d = {rx_hdr_i.local_node_identifier, rx_hdr_i.switch_identifier}; // RULE7 RULE8
            if ((rx_hdr_i.len == `CRG_LEN_SHORT) || (rx_hdr_i.len == `CRG_LEN_LONG)) begin
               // Compat form decoded; meaning of the flag follows direction.
               rflags_d = rbuf_n[63:48]; // RULE5
               rhw_d    = rbuf_n[47:0];
               rstat_d  = {rx_hdr_i.downlink & rbuf_n[48 + 8],   // RULE6 RULE10
                           rx_hdr_i.len == `CRG_LEN_LONG, rx_hdr_i.downlink,
                           1'b0, 1'b1, 1'b1};
               // On uplink bit 56 is the sender's own capability. RULE9
            end else begin
               rstat_d = {1'b0, 1'b0, rx_hdr_i.downlink, 1'b1, 1'b0, 1'b1}; // RULE5
            end
         end
      end
   end

   // All state registers.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ctrl_q <= `CRG_CTRL_RST;  ids_q <= `CRG_IDS_RST;  hw_q <= '0;
         prdata_q <= '0;  pready_q <= 1'b0;  pslverr_q <= 1'b0;
         state_q <= CRG_IDLE;  idx_q <= '0;  timer_q <= '0;  retx_q <= '0;
         failed_q <= 1'b0;  tvalid_q <= 1'b0;  tbyte_q <= '0;  tlast_q <= 1'b0;
         thdr_q <= '0;  rcnt_q <= '0;  rbuf_q <= '0;  rflags_q <= '0;
         rids_q <= '0;  rhw_q <= '0;  rstat_q <= '0;
      end else begin
         ctrl_q <= ctrl_d;  ids_q <= ids_d;  hw_q <= hw_d;
         prdata_q <= prdata_d;  pready_q <= pready_d;  pslverr_q <= pslverr_d;
         state_q <= state_d;  idx_q <= idx_d;  timer_q <= timer_d;  retx_q <= retx_d;
         failed_q <= failed_d;  tvalid_q <= tvalid_d;  tbyte_q <= tbyte_d;
         tlast_q <= tlast_d;  thdr_q <= thdr_d;  rcnt_q <= rcnt_d;  rbuf_q <= rbuf_d;
         rflags_q <= rflags_d;  rids_q <= rids_d;  rhw_q <= rhw_d;  rstat_q <= rstat_d;
      end
   end

   assign prdata_o  = prdata_q;
   assign pready_o  = pready_q;
   assign pslverr_o = pslverr_q;
   assign tx_valid_o = tvalid_q;
   assign tx_byte_o  = tbyte_q;
   assign tx_last_o  = tlast_q;
   assign tx_hdr_o   = thdr_q;

   // Checks beside the logic.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   a_tx_ctype_one: assert property (tx_valid_o |-> tx_hdr_o.control &&
      tx_hdr_o.ctype == 9'h001) else $error("tx control type not 1"); // RULE3
   a_ctype_shared: assert property (rx_valid_i && rx_last_i && rx_hdr_i.control &&
      rx_hdr_i.ctype == 9'h001 |=> rstat_q[0]) else $error("type 1 not taken"); // RULE1
   a_req_compat_len: assert property (tx_valid_o && !tx_hdr_o.downlink |->
      tx_hdr_o.len == 9'd8 || tx_hdr_o.len == 9'd40) else $error("request not compat"); // RULE4
   a_rx_compat_len: assert property (rx_valid_i && rx_last_i && rx_match &&
      (rx_hdr_i.len == 9'd8 || rx_hdr_i.len == 9'd40) |=> rstat_q[1] && !rstat_q[2])
      else $error("compat length not decoded"); // RULE5
   a_rx_legacy_len: assert property (rx_valid_i && rx_last_i && rx_match &&
      rx_hdr_i.len != 9'd8 && rx_hdr_i.len != 9'd40 |=> rstat_q[2] && !rstat_q[1])
      else $error("legacy length not flagged"); // RULE5
   a_rx_dir_path: assert property (rx_valid_i && rx_last_i && rx_match &&
      !rx_hdr_i.downlink |=> !rstat_q[5]) else $error("uplink flag read as path"); // RULE6
   a_tx_ids_kept: assert property (tx_valid_o |-> tx_hdr_o.switch_identifier == ids_q[7:0]
      && tx_hdr_o.local_node_identifier == ids_q[21:8]) else $error("ids differ"); // RULE7
   a_rx_lnid_kept: assert property (rx_valid_i && rx_last_i && rx_match |=>
      rids_q[21:8] == $past(rx_hdr_i.local_node_identifier)) else $error("lnid lost"); // RULE8
   a_path_flag: assert property (tx_valid_o && tx_hdr_o.downlink && idx_q == 6'd0 |->
      tx_byte_o[0] == path_ok) else $error("path aggregation flag wrong"); // RULE10
   a_neg_roam_spc: assert property (tx_valid_o && idx_q == 6'd0 |->
      tx_byte_o[7:4] == ctrl_q[15:12]) else $error("flag bits wrong"); // RULE11
   a_retx_restart: assert property (state_q == CRG_WAIT && timer_q == 32'd1 && !resp_seen &&
      retx_q != 4'(MAX_RETX) |=> state_q == CRG_FETCH && idx_q == 6'd0 ##2 tx_valid_o)
      else $error("no retransmission"); // RULE2

   c_req_done: cover property (state_q == CRG_WAIT && resp_seen);
   c_retx: cover property (state_q == CRG_WAIT ##1 state_q == CRG_FETCH);
   c_rx_long: cover property (rx_valid_i && rx_last_i && rx_match && rx_hdr_i.len == 9'd40);
   c_rx_legacy: cover property (rx_valid_i && rx_last_i && rx_match && rx_hdr_i.len == 9'd10);
endmodule : crg_codec

// ---- rtl/crg_defs.svh ----
/*
 * Constants of the compatibility registration codec: register offsets,
 * field positions, reset values, packet codes and timing figures.
 * Assumes inclusion by bare name from the codec module.
 */
//
// Summary of operation
// RULE1 - Compat and standard control type share codes.
// RULE2 - Control packets retransmit like ordinary control packets.
// RULE3 - Control type 1 means compat registration.
// RULE4 - Registration requests always use compat format.
// RULE5 - Payload 8 or 40 compat, else legacy.
// RULE6 - Decode meaning by packet direction.
// RULE7 - Switch identifier names the registering switch.
// RULE8 - Local node identifier carries assigned node.
// RULE9 - Uplink aggregation flag reports own capability.
// RULE10 - Downlink flag set only if whole path aggregates.
// RULE11 - Negative flag one for negative registration.
// RULE12 - Roaming flag one when moving switches.
// RULE13 - Two-bit security capability encodes profile level.
// RULE14 - Flags, time, hardware address, then two keys.
`ifndef CRG_DEFS_SVH
`define CRG_DEFS_SVH

// One control type table serves both headers.
`define CRG_CTYPE_REG      9'h001
// Compat payload lengths in bytes.
`define CRG_LEN_SHORT      9'h008
`define CRG_LEN_LONG       9'h028
// Register byte offsets.
`define CRG_OFF_CTRL       8'h00
`define CRG_OFF_IDS        8'h04
`define CRG_OFF_HW_LO      8'h08
`define CRG_OFF_HW_HI      8'h0c
`define CRG_OFF_STATUS     8'h10
`define CRG_OFF_RX_IDS     8'h14
`define CRG_OFF_RX_HW_LO   8'h18
`define CRG_OFF_RX_HW_HI   8'h1c
`define CRG_OFF_KEY_BASE   8'h20
// Control register fields.
`define CRG_CTRL_DOWN      16
`define CRG_CTRL_LONG      17
`define CRG_CTRL_PATH_LSB  18
`define CRG_CTRL_HOPS_LSB  26
`define CRG_CTRL_START     31
// Reset values.
`define CRG_CTRL_RST       32'h0000_0000
`define CRG_IDS_RST        22'h00_0000
// Timing: retransmission wait and clock rate; retransmission limit.
`define CRG_RETX_TIME_US   1000
`define CRG_CLK_MHZ        25
`define CRG_MAX_RETX       3

`endif

// ---- rtl/crg_key_mem.sv ----
/*
 * Small key store: one write port, one read port with registered data.
 * Assumes a single clock; read data follow the address by one cycle.
 */
`timescale 1ns/1ps
module crg_key_mem #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input  wire logic                     clk_sys_i,
   input  wire logic                     rst_n_i,
   // Write port.
   input  wire logic                     we_i,
   input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
   input  wire logic [WIDTH-1:0]         wdata_i,
   // Read port.
   input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
   output logic      [WIDTH-1:0]         rdata_o
);
   import crg_pkg::*;

   // The array size must be a power of two above one.
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("crg_key_mem: DEPTH must be a power of two");
      end
   end

   logic [WIDTH-1:0] mem_q [DEPTH];   // Storage, no reset needed.
   logic [WIDTH-1:0] rdata_q;         // Registered read data.

   // Storage writes; the registered read is in the block below.
   always_ff @(posedge clk_sys_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
   end

   // Read register is reset so the output is defined at once.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= mem_q[raddr_i];
      end
   end

   assign rdata_o = rdata_q;
endmodule : crg_key_mem

// ---- rtl/crg_pkg.sv ----
/*
 * Types of the compatibility registration codec.
 * Assumes crg_defs.svh is on the include path.
 */
package crg_pkg;
   // Packet header fields seen beside the payload.
   typedef struct packed {
      logic       control;   // Control packet when high.
      logic [8:0] ctype;     // Control type code.
      logic [8:0] len;       // Payload length in bytes.
      logic [7:0] switch_identifier;
      logic [13:0] local_node_identifier;
      logic       downlink;  // Direction, high for downlink.
   } crg_hdr_t;

   // First payload word: flags and time.
   typedef struct packed {
      logic       negative_flag;
      logic       roaming_flag;
      logic [1:0] security_capability;
      logic       cap_robust;
      logic       cap_compat;
      logic       cap_switch;
      logic       aggregation_capable_flag;
      logic       cap_cfp;
      logic       cap_direct;
      logic       cap_mcast;
      logic       cap_prm;
      logic [3:0] time_field;
   } crg_flags_t;

   // Transmit sequencer states, Gray from IDLE through FETCH, LOAD and SEND to WAIT.
   typedef enum logic [2:0] {
      CRG_IDLE  = 3'h0,
      CRG_FETCH = 3'h1,
      CRG_LOAD  = 3'h3,
      CRG_SEND  = 3'h2,
      CRG_WAIT  = 3'h6
   } crg_state_t;
endpackage : crg_pkg

// ---- tb/crg_peer_model.sv ----
/*
 * Peer node model: accepts the transmit byte stream and sends packets into the codec.
 * Assumes one clock; the bench calls send() and reads got, hdr_q and n_last.
 */
`timescale 1ns/1ps
module crg_peer_model (
   // Clock, reset and pace.
   input  wire logic              clk_sys_i,
   input  wire logic              rst_n_i,
   input  wire logic              slow_i,
   // Transmit stream from the codec.
   input  wire logic              tx_valid_i,
   input  wire logic [7:0]        tx_byte_i,
   input  wire logic              tx_last_i,
   input  wire crg_pkg::crg_hdr_t tx_hdr_i,
   output logic                   tx_ready_o,
   // Receive stream into the codec.
   output logic                   rx_valid_o,
   output logic [7:0]             rx_byte_o,
   output logic                   rx_last_o,
   output crg_pkg::crg_hdr_t      rx_hdr_o
);
   import crg_pkg::*;
   logic [7:0] got[$];   // Accepted bytes in order.
   crg_hdr_t   hdr_q;    // Header seen with the latest accepted byte.
   int         n_last = 0;   // Count of accepted final bytes.

   // Sink: a slow peer stalls every other cycle to stretch the hold time.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_ready_o <= 1'b0;
      end else begin
         tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
         if (tx_valid_i && tx_ready_o) begin
            got.push_back(tx_byte_i);
            hdr_q <= tx_hdr_i;
            if (tx_last_i) begin
               n_last <= n_last + 1;
            end
         end
      end
   end

   // Idle receive lines at time zero.
   initial begin
      rx_valid_o = 1'b0;
      rx_byte_o  = 8'h5a;
      rx_last_o  = 1'b0;
      rx_hdr_o   = '0;
   end

   // Source: payload bytes count up from 0x90; released lines are inverted, not held.
   task automatic send(input crg_hdr_t hdr, input int len);
      for (int i = 0; i < len; i++) begin
         @(posedge clk_sys_i);
         rx_valid_o <= 1'b1;
         rx_byte_o  <= 8'h90 + 8'(i);
         rx_last_o  <= (i == len - 1);
         rx_hdr_o   <= hdr;
      end
      @(posedge clk_sys_i);
      rx_valid_o <= 1'b0;
      rx_last_o  <= 1'b0;
      rx_byte_o  <= ~rx_byte_o;
      rx_hdr_o   <= crg_hdr_t'(~hdr);
   endtask : send
endmodule : crg_peer_model

// ---- tb/testbench.sv ----
/*
 * Self-checking bench of the registration codec with an APB master and a peer model.
 * Assumes the codec's contract: one APB wait state, registered streams.
 */
`timescale 1ns/1ps
module testbench;
   import crg_pkg::*;
   localparam int RETX = 20;   // Shortened retransmission wait.
   localparam int MAXR = 3;    // Retransmission limit.
   logic        clk_sys_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic        tx_valid, tx_last, tx_ready, rx_valid, rx_last, slow;
   logic [7:0]  tx_byte, rx_byte;
   crg_hdr_t    tx_hdr, rx_hdr;
   int          n_fail = 0, checked = 0, cyc = 0;

   crg_codec #(.RETX_CYCLES(RETX), .MAX_RETX(MAXR)) dut (.clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .tx_valid_o(tx_valid), .tx_byte_o(tx_byte),
      .tx_last_o(tx_last), .tx_hdr_o(tx_hdr), .tx_ready_i(tx_ready), .rx_valid_i(rx_valid),
      .rx_byte_i(rx_byte), .rx_last_i(rx_last), .rx_hdr_i(rx_hdr));
   crg_peer_model peer (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
      .tx_valid_i(tx_valid), .tx_byte_i(tx_byte), .tx_last_i(tx_last), .tx_hdr_i(tx_hdr),
      .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte),
      .rx_last_o(rx_last), .rx_hdr_o(rx_hdr));

   // Clock of 40 ns period.
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   // Hang guard: under a thousand cycles are needed, so the ceiling is generous.
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end

   task automatic complete_run();
      if (n_fail == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic e);
      @(posedge clk_sys_i);
      psel_i    <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clk_sys_i);
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      e  = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        e;
      apb(1'b1, a, d, rd, e);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                        input logic xe);
      logic [31:0] rd;
      logic        e;
      apb(1'b0, a, 32'h0, rd, e);
      check(64'(rd & m), 64'(x));
      check(64'(e), 64'(xe));
   endtask : rdchk

   // Waits, bounded, until n bytes have reached the peer.
   task automatic wait_bytes(input int n);
      for (int w = 0; w < 3000 && peer.got.size() < n; w++) begin
         @(posedge clk_sys_i);
      end
   endtask : wait_bytes

   // Compares eight received bytes from base on, most significant first.
   task automatic chk_seq(input logic [63:0] x, input int base);
      for (int i = 0; i < 8; i++) begin
         check(64'(peer.got[base + i]), 64'(x[63 - 8*i -: 8]));
      end
   endtask : chk_seq

   // Reset values, unmapped and unaligned places, write-only key area.
   task automatic t_reset_regs();
      rdchk(8'h00, 32'hffff_ffff, 32'h0, 1'b0);
      rdchk(8'h04, 32'hffff_ffff, 32'h0, 1'b0);
      rdchk(8'h10, 32'hffff_ffff, 32'h0, 1'b0);
      rdchk(8'h40, 32'h0, 32'h0, 1'b1);
      rdchk(8'h02, 32'h0, 32'h0, 1'b1);
      wr(8'h20, 32'hdead_beef);
      rdchk(8'h20, 32'hffff_ffff, 32'h0, 1'b0);
   endtask : t_reset_regs

   // Uplink request to a stalling peer, answered before the wait runs out.
   task automatic t_uplink();
      peer.got.delete();
      slow <= 1'b1;
      wr(8'h04, 32'h0012_342a);
      wr(8'h08, 32'h3344_5566);
      wr(8'h0c, 32'h0000_1122);
      wr(8'h00, 32'h8000_d5a3);
      wait_bytes(8);
      peer.send('{control:1'b1, ctype:9'h001, len:9'h008, switch_identifier:8'h2a,
                  local_node_identifier:14'h1234, downlink:1'b1}, 8);
      check(64'(peer.hdr_q), 64'({1'b1, 9'h001, 9'h008, 8'h2a, 14'h1234, 1'b0}));
      chk_seq(64'hd5a3_1122_3344_5566, 0);
      repeat (RETX + 10) @(posedge clk_sys_i);
      check(64'(peer.got.size()), 64'd8);
      rdchk(8'h10, 32'hffff_0fff, 32'h9091_000b, 1'b0);
      rdchk(8'h14, 32'h003f_ffff, 32'h0012_342a, 1'b0);
      rdchk(8'h18, 32'hffff_ffff, 32'h9495_9697, 1'b0);
      rdchk(8'h1c, 32'h0000_ffff, 32'h0000_9293, 1'b0);
   endtask : t_uplink

   // Unanswered uplink: resent from byte 0 the full count of times, then failed.
   task automatic t_retx();
      logic [31:0] s;
      logic        e;
      int          l0;
      peer.got.delete();
      slow <= 1'b0;
      l0 = peer.n_last;
      wr(8'h00, 32'h8000_1234);
      wait_bytes(8 * (MAXR + 1));
      s = 32'h0;
      for (int i = 0; i < 60 && s[7] !== 1'b1; i++) begin
         apb(1'b0, 8'h10, 32'h0, s, e);
      end
      check(64'(s & 32'h0000_0fc0), 64'h0380);
      check(64'(peer.got.size()), 64'(8 * (MAXR + 1)));
      check(64'(peer.n_last - l0), 64'(MAXR + 1));
      chk_seq(64'h1234_1122_3344_5566, 8 * MAXR);
   endtask : t_retx

   // Long downlink response; aggregation flag comes from the path, not the own bit.
   task automatic t_downlink(input logic [7:0] path, input logic [2:0] hops,
                             input logic own, input logic agg);
      peer.got.delete();
      for (int k = 0; k < 8; k++) begin
         wr(8'h20 + 8'(4 * k), {4{8'hc0 + 8'(k)}});
      end
      wr(8'h00, {1'b1, 2'b00, hops, path, 1'b1, 1'b1, 7'h30, own, 8'h00});
      wait_bytes(40);
      check(64'(peer.hdr_q), 64'({1'b1, 9'h001, 9'h028, 8'h2a, 14'h1234, 1'b1}));
      chk_seq({7'h30, agg, 8'h00, 48'h1122_3344_5566}, 0);
      for (int j = 0; j < 4; j++) begin
         chk_seq({{4{8'hc0 + 8'(2*j)}}, {4{8'hc0 + 8'(2*j + 1)}}}, 8 + 8*j);
      end
   endtask : t_downlink

   // Received kinds: legacy length, long compat, foreign control type.
   task automatic t_rx_kinds();
      crg_hdr_t h;
      h = '{control:1'b1, ctype:9'h001, len:9'h00a, switch_identifier:8'h55,
            local_node_identifier:14'h0abc, downlink:1'b0};
      peer.send(h, 10);
      rdchk(8'h10, 32'h0000_003f, 32'h0000_0005, 1'b0);
      rdchk(8'h14, 32'h003f_ffff, 32'h000a_bc55, 1'b0);
      h.len = 9'h028;
      h.downlink = 1'b1;
      peer.send(h, 40);
      rdchk(8'h10, 32'hffff_003f, 32'h9091_001b, 1'b0);
      h.ctype = 9'h002;
      h.switch_identifier = 8'h77;
      peer.send(h, 8);
      rdchk(8'h14, 32'h003f_ffff, 32'h000a_bc55, 1'b0);
   endtask : t_rx_kinds

   // Main sequence.
   initial begin
      rst_n_i   = 1'b0;
      psel_i    = 1'b0;
      penable_i = 1'b0;
      pwrite_i  = 1'b0;
      paddr_i   = 8'h00;
      pwdata_i  = 32'h0;
      slow      = 1'b0;
      repeat (5) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      t_reset_regs();
      t_uplink();
      t_retx();
      t_downlink(8'h03, 3'h2, 1'b0, 1'b1);
      t_downlink(8'h05, 3'h3, 1'b1, 1'b0);
      t_rx_kinds();
      complete_run();
   end
endmodule : testbench
